// file: include/isrfs_pkg.sv
// Package: register map, status codes, timing and types
package isrfs_pkg;
	localparam int          AW          = 3;
	localparam logic [2:0]  OFF_CTRL    = 3'h0;
	localparam logic [2:0]  OFF_STATUS  = 3'h1;
	localparam logic [2:0]  OFF_DATA    = 3'h2;
	localparam logic [2:0]  OFF_OWNADDR = 3'h3;
	localparam int          B_IRQ       = 7;
	localparam int          B_ACKEN     = 6;
	localparam int          B_BEGIN     = 5;
	localparam int          B_END       = 4;
	localparam int          B_IFEN      = 2;
	localparam int          B_GCEN      = 0;
	localparam logic [7:0]  RST_OWNADDR = 8'h00;
	localparam logic [7:0]  RST_DATA    = 8'hFF;
	localparam logic [6:0]  GCA_ADDR    = 7'h00;
	localparam logic [7:0]  C_NONE      = 8'hF8;
	localparam logic [7:0]  C_START     = 8'h08;
	localparam logic [7:0]  C_SR_ADDR   = 8'h60;
	localparam logic [7:0]  C_SR_ARB    = 8'h68;
	localparam logic [7:0]  C_SR_GCA    = 8'h70;
	localparam logic [7:0]  C_SR_GARB   = 8'h78;
	localparam logic [7:0]  C_SR_ACK    = 8'h80;
	localparam logic [7:0]  C_SR_NACK   = 8'h88;
	localparam logic [7:0]  C_SR_GACK   = 8'h90;
	localparam logic [7:0]  C_SR_GNACK  = 8'h98;
	localparam logic [7:0]  C_ST_ADDR   = 8'hA8;
	localparam logic [7:0]  C_ST_ARB    = 8'hB0;
	localparam logic [7:0]  C_ST_ACK    = 8'hB8;
	localparam logic [7:0]  C_ST_NACK   = 8'hC0;
	localparam logic [7:0]  C_ST_LAST   = 8'hC8;
	localparam int          CLK_NS      = 20;
	localparam int          T_HOLD_NS   = 4000;
	localparam int          HOLD_CYC    = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
	typedef struct packed {
		logic ackEn;
		logic beginReq;
		logic endReq;
		logic ifaceEn;
	} isrfs_ctrl_t;
endpackage

// file: core/isrfs_core.sv
// Two-wire slave: receive path, final send status, sleep wake, Avalon-MM registers
//
// Operation
// [R1] Last byte sent with ack disabled but master acked: code C8.
// [R2] Clearing flag after final byte with ack off: not addressed, recognise nothing.
// [R3] Clearing with ack on: not addressed, own address and enabled GENERAL_CALL_ADDRESS recognised.
// [R4] Begin request set at that clear: START once the bus is free.
// [R5] Own address matched against top seven bits of own address register.
// [R6] Own address LSB set enables general call 0x00, else ignored.
// [R7] Software sets enable and ack enable, clears begin and end requests.
// [R8] Direction bit zero selects receive, one selects send.
// [R9] Own address plus write: flag set, valid status code shown.
// [R10] Addressed while own START pending: codes 68 or 78. With a read address this design reports B0 instead.
// [R11] Software treats status prescaler bits as zero.
// [R12] Ack enable cleared: next received byte gets not-acknowledge.
// [R13] Ack enable zero: own address not acked, bus still watched.
// [R14] In sleep with ack enable set, address still recognised and acked.
// [R15] Match in sleep wakes part, SCL held low until flag cleared.
// [R16] Data register not updated by the bus while asleep.
// [R17] Byte sent and master not-acked: code C0.
// [R18] Own address with read acked: code A8.
// [R19] Own address with write acked: code 60.
// [R20] While the flag is set in a slave state, SCL is held low.
//
// The Avalon-MM slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module isrfs_core (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset,
	// Avalon-MM slave
	input  wire logic [2:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Two-wire bus pins
	input  wire logic        sclIn,
	input  wire logic        sdaIn,
	output logic             sclOut,
	output logic             sclOe,
	output logic             sdaOut,
	output logic             sdaOe,
	// Power management
	input  wire logic        sleepActive,
	output logic             wakeReq
);
	typedef enum {S_IDLE, S_GEN, S_ADDR, S_AACK, S_RX, S_RACK, S_TX, S_TACK, S_WAIT} isrfs_st_t;
	typedef enum {X_TX, X_RX, X_FINAL, X_MASTER} isrfs_ctx_t;

	isrfs_st_t            state_q;
	isrfs_ctx_t           ctx_q;
	isrfs_pkg::isrfs_ctrl_t ctrl_q;
	logic [7:0]           own_q, data_q, shift_q, code_q, rdata_q;
	logic [3:0]           bitCnt_q;
	logic [7:0]           holdCnt_q;
	logic [2:0]           sclSync_q, sdaSync_q;
	logic                 sclF_q, sdaF_q, avWait_q, irqFlag_q, sclOe_q, sdaOe_q, wake_q;
	logic                 dir_q, gca_q, arb_q, ackNext_q, gotAck_q, last_q, startPend_q, busy_q;
	logic                 sclNew, sdaNew, sclRise, sclFall, startDet, stopDet;
	logic                 accept, wrCtrl, wrData, irqClr, ownHit, gcaHit, addrHit;

	function automatic logic [7:0] rx_code(input logic g, input logic a);
		if (g)
			rx_code = a ? isrfs_pkg::C_SR_GACK : isrfs_pkg::C_SR_GNACK;
		else
			rx_code = a ? isrfs_pkg::C_SR_ACK : isrfs_pkg::C_SR_NACK;
	endfunction

	// --------------------------------------------------------------
	// Pin sampling and bus conditions
	// --------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sclSync_q <= 3'h7;
			sdaSync_q <= 3'h7;
			sclF_q    <= 1'b1;
			sdaF_q    <= 1'b1;
		end else begin
			sclSync_q <= {sclSync_q[1:0], sclIn};
			sdaSync_q <= {sdaSync_q[1:0], sdaIn};
			sclF_q    <= sclNew;
			sdaF_q    <= sdaNew;
		end
	end

	assign sclNew   = (sclSync_q[1] == sclSync_q[2]) ? sclSync_q[2] : sclF_q;
	assign sdaNew   = (sdaSync_q[1] == sdaSync_q[2]) ? sdaSync_q[2] : sdaF_q;
	assign sclRise  = sclNew & ~sclF_q;
	assign sclFall  = ~sclNew & sclF_q;
	assign startDet = sclF_q & sclNew & sdaF_q & ~sdaNew;
	assign stopDet  = sclF_q & sclNew & ~sdaF_q & sdaNew;

	// Address decode: own address needs ack enable, general call also needs its enable
	assign ownHit  = shift_q[7:1] == own_q[7:1];                              // see [R5]
	assign gcaHit  = (shift_q[7:1] == isrfs_pkg::GCA_ADDR) & own_q[isrfs_pkg::B_GCEN]; // see [R6]
	assign addrHit = ctrl_q.ackEn & (ownHit | gcaHit);                        // see [R13]

	// --------------------------------------------------------------
	// Avalon-MM slave, one wait state per access
	// --------------------------------------------------------------
	assign accept = (avs_read | avs_write) & ~avWait_q;
	assign wrCtrl = accept & avs_write & (avs_address == isrfs_pkg::OFF_CTRL);
	assign wrData = accept & avs_write & (avs_address == isrfs_pkg::OFF_DATA);
	assign irqClr = wrCtrl & avs_writedata[isrfs_pkg::B_IRQ];

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			avWait_q <= 1'b1;
			rdata_q  <= 8'h00;
		end else begin
			avWait_q <= ~((avs_read | avs_write) & avWait_q);
			if (avs_read & avWait_q) begin
				case (avs_address)
					isrfs_pkg::OFF_CTRL:    rdata_q <= {irqFlag_q, ctrl_q.ackEn, ctrl_q.beginReq,
						ctrl_q.endReq, 1'b0, ctrl_q.ifaceEn, 2'h0};
					isrfs_pkg::OFF_STATUS:  rdata_q <= {code_q[7:3], 3'h0};
					isrfs_pkg::OFF_DATA:    rdata_q <= data_q;
					isrfs_pkg::OFF_OWNADDR: rdata_q <= own_q;
					default:                rdata_q <= 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ctrl_q <= '0;
			own_q  <= isrfs_pkg::RST_OWNADDR;
		end else begin
			if (wrCtrl) begin
				ctrl_q.ackEn    <= avs_writedata[isrfs_pkg::B_ACKEN];
				ctrl_q.beginReq <= avs_writedata[isrfs_pkg::B_BEGIN];
				ctrl_q.endReq   <= avs_writedata[isrfs_pkg::B_END];
				ctrl_q.ifaceEn  <= avs_writedata[isrfs_pkg::B_IFEN];
			end
			if (accept & avs_write & (avs_address == isrfs_pkg::OFF_OWNADDR))
				own_q <= avs_writedata[7:0];
		end
	end

	// --------------------------------------------------------------
	// Slave sequencer
	// --------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_q     <= S_IDLE;
			ctx_q       <= X_RX;
			shift_q     <= 8'h00;
			bitCnt_q    <= 4'h0;
			holdCnt_q   <= 8'h00;
			code_q      <= isrfs_pkg::C_NONE;
			data_q      <= isrfs_pkg::RST_DATA;
			{irqFlag_q, sclOe_q, sdaOe_q, wake_q, dir_q, gca_q, arb_q} <= 7'h00;
			{ackNext_q, gotAck_q, last_q, startPend_q, busy_q} <= 5'h00;
		end else begin
			if (irqClr)
				irqFlag_q <= 1'b0;
			if (wrData)
				data_q <= avs_writedata[7:0];
			if (startDet)
				busy_q <= 1'b1;
			if (stopDet)
				busy_q <= 1'b0;
			if (!ctrl_q.ifaceEn) begin
				state_q <= S_IDLE;
				sdaOe_q <= 1'b0;
				sclOe_q <= 1'b0;
			end else if (stopDet && state_q != S_GEN) begin
				state_q <= S_IDLE;
				sdaOe_q <= 1'b0;
			end else if (startDet && state_q != S_GEN) begin
				state_q  <= S_ADDR;
				bitCnt_q <= 4'h0;
				sdaOe_q  <= 1'b0;
			end else begin
				case (state_q)
					S_IDLE: begin
						if (startPend_q && !busy_q) begin                 // see [R4]
							sdaOe_q     <= 1'b1;
							holdCnt_q   <= 8'h00;
							startPend_q <= 1'b0;
							state_q     <= S_GEN;
						end
					end
					S_GEN: begin
						holdCnt_q <= holdCnt_q + 8'h01;
						if (holdCnt_q == 8'(isrfs_pkg::HOLD_CYC - 1)) begin
							sclOe_q   <= 1'b1;
							irqFlag_q <= 1'b1;
							code_q    <= isrfs_pkg::C_START;
							ctx_q     <= X_MASTER;
							state_q   <= S_WAIT;
						end
					end
					S_ADDR: begin
						if (sclRise) begin
							shift_q  <= {shift_q[6:0], sdaNew};
							bitCnt_q <= bitCnt_q + 4'h1;
						end
						if (sclFall && bitCnt_q == 4'h8) begin
							if (addrHit) begin                                // see [R14]
								sdaOe_q <= 1'b1;
								dir_q   <= shift_q[0];
								gca_q   <= ~ownHit;
								arb_q   <= startPend_q;
								wake_q  <= sleepActive;                       // see [R15]
								state_q <= S_AACK;
							end else begin
								state_q <= S_IDLE;                            // see [R13]
							end
						end
					end
					S_AACK: begin
						if (sclFall) begin
							sdaOe_q   <= 1'b0;
							sclOe_q   <= 1'b1;
							irqFlag_q <= 1'b1;                                // see [R9]
							state_q   <= S_WAIT;
							ctx_q     <= dir_q ? X_TX : X_RX;                 // see [R8]
							if (dir_q)
								code_q <= arb_q ? isrfs_pkg::C_ST_ARB : isrfs_pkg::C_ST_ADDR; // see [R18]
							else if (gca_q)
								code_q <= arb_q ? isrfs_pkg::C_SR_GARB : isrfs_pkg::C_SR_GCA; // see [R10]
							else
								code_q <= arb_q ? isrfs_pkg::C_SR_ARB : isrfs_pkg::C_SR_ADDR; // see [R19]
						end
					end
					S_RX: begin
						if (sclRise) begin
							shift_q  <= {shift_q[6:0], sdaNew};
							bitCnt_q <= bitCnt_q + 4'h1;
						end
						if (sclFall && bitCnt_q == 4'h8) begin
							if (!sleepActive)
								data_q <= shift_q;                            // see [R16]
							sdaOe_q   <= ctrl_q.ackEn;                        // see [R12]
							ackNext_q <= ctrl_q.ackEn;
							state_q   <= S_RACK;
						end
					end
					S_RACK: begin
						if (sclFall) begin
							sdaOe_q   <= 1'b0;
							sclOe_q   <= 1'b1;
							irqFlag_q <= 1'b1;
							code_q    <= rx_code(gca_q, ackNext_q);
							ctx_q     <= ackNext_q ? X_RX : X_FINAL;
							state_q   <= S_WAIT;
						end
					end
					S_TX: begin
						if (sclFall) begin
							if (bitCnt_q == 4'h8) begin
								sdaOe_q <= 1'b0;
								state_q <= S_TACK;
							end else begin
								sdaOe_q  <= ~shift_q[6];
								shift_q  <= {shift_q[6:0], 1'b0};
								bitCnt_q <= bitCnt_q + 4'h1;
							end
						end
					end
					S_TACK: begin
						if (sclRise)
							gotAck_q <= ~sdaNew;
						if (sclFall) begin
							sclOe_q   <= 1'b1;
							irqFlag_q <= 1'b1;
							state_q   <= S_WAIT;
							if (!gotAck_q) begin
								code_q <= isrfs_pkg::C_ST_NACK;               // see [R17]
								ctx_q  <= X_FINAL;
							end else if (last_q) begin
								code_q <= isrfs_pkg::C_ST_LAST;               // see [R1]
								ctx_q  <= X_FINAL;
							end else begin
								code_q <= isrfs_pkg::C_ST_ACK;
								ctx_q  <= X_TX;
							end
						end
					end
					S_WAIT: begin
						if (!irqFlag_q) begin                                 // see [R20]
							sclOe_q <= 1'b0;
							wake_q  <= 1'b0;
							case (ctx_q)
								X_TX: begin
									sdaOe_q  <= ~data_q[7];
									shift_q  <= data_q;
									bitCnt_q <= 4'h1;
									last_q   <= ~ctrl_q.ackEn;
									state_q  <= S_TX;
								end
								X_RX: begin
									bitCnt_q <= 4'h0;
									state_q  <= S_RX;
								end
								X_FINAL: begin
									startPend_q <= ctrl_q.beginReq;           // see [R4]
									state_q     <= S_IDLE;                    // see [R2] [R3]
								end
								default: begin
									sdaOe_q <= 1'b0;
									busy_q  <= 1'b0;
									state_q <= S_IDLE;
								end
							endcase
						end
					end
					default: state_q <= S_IDLE;
				endcase
			end
		end
	end

	// Open-drain pins only ever pull low
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sclOut <= 1'b0;
			sdaOut <= 1'b0;
		end else begin
			sclOut <= 1'b0;
			sdaOut <= 1'b0;
		end
	end

	assign sclOe           = sclOe_q;
	assign sdaOe           = sdaOe_q;
	assign wakeReq         = wake_q;
	assign avs_waitrequest = avWait_q;
	assign avs_readdata    = {24'h000000, rdata_q};

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence addrDone;
		state_q == S_ADDR && sclFall && bitCnt_q == 4'h8 && ctrl_q.ifaceEn && !startDet && !stopDet;
	endsequence
	sequence aackEnd;
		state_q == S_AACK && sclFall && ctrl_q.ifaceEn && !startDet && !stopDet;
	endsequence
	sequence finalClear;
		state_q == S_WAIT && ctx_q == X_FINAL && !irqFlag_q && ctrl_q.ifaceEn && !startDet && !stopDet;
	endsequence

	a_last_byte_code: assert property (state_q == S_TACK && sclFall && gotAck_q && last_q
		&& ctrl_q.ifaceEn && !startDet && !stopDet |=> code_q == 8'hC8 && irqFlag_q) // see [R1]
		else $error("final acked byte not reported");
	a_final_release: assert property (finalClear |=> state_q == S_IDLE && !sclOe_q ##1 !sclOe_q) // see [R2]
		else $error("final clear did not release bus");
	a_start_queued: assert property (finalClear ##0 ctrl_q.beginReq |=> startPend_q) // see [R4]
		else $error("begin request lost");
	a_own_match: assert property (addrDone ##0 (ctrl_q.ackEn && ownHit) |=> state_q == S_AACK && sdaOe_q) // see [R5]
		else $error("own address not acked");
	a_gca_ignore: assert property (addrDone ##0 (!own_q[0] && !ownHit && shift_q[7:1] == 7'h00)
		|=> state_q == S_IDLE && !sdaOe_q) // see [R6]
		else $error("general call acked while disabled");
	a_dir_select: assert property (aackEnd |=> (ctx_q == X_TX) == dir_q) // see [R8]
		else $error("direction bit misread");
	a_write_flag: assert property (aackEnd ##0 (!dir_q && !gca_q && !arb_q) |=> irqFlag_q && code_q == 8'h60) // see [R19]
		else $error("write address status wrong");
	a_arb_code: assert property (aackEnd ##0 (!dir_q && arb_q) |=> code_q == 8'h68 || code_q == 8'h78) // see [R10]
		else $error("arbitration code wrong");
	a_nack_byte: assert property (state_q == S_RX && sclFall && bitCnt_q == 4'h8 && !ctrl_q.ackEn
		&& ctrl_q.ifaceEn && !startDet && !stopDet |=> !sdaOe_q && !ackNext_q) // see [R12]
		else $error("byte acked with ack disabled");
	a_isolated: assert property (addrDone ##0 !ctrl_q.ackEn |=> state_q == S_IDLE && !sdaOe_q) // see [R13]
		else $error("address acked with ack disabled");
	a_sleep_wake: assert property (addrDone ##0 (addrHit && sleepActive) |=> wake_q [*2]) // see [R14]
		else $error("no wake on sleep match");
	a_wake_hold: assert property (wake_q && state_q == S_WAIT && irqFlag_q |-> sclOe_q) // see [R15]
		else $error("scl released during wake");
	a_data_frozen: assert property (sleepActive && !wrData |=> data_q == $past(data_q)) // see [R16]
		else $error("data register moved in sleep");
	a_read_addr: assert property (aackEnd ##0 (dir_q && !arb_q) |=> code_q == 8'hA8) // see [R18]
		else $error("read address status wrong");
endmodule

// file: bench/isrfs_master_model.sv
// Two-wire bus master model with open-drain SCL and SDA
`timescale 1ns/1ps
module isrfs_master_model (
	// Clock
	input  wire logic clk,
	// Slave pull-downs
	input  wire logic sclOe,
	input  wire logic sdaOe,
	// Wire levels
	output logic      sclIn,
	output logic      sdaIn
);
	logic mScl = 1'h0;
	logic mSda = 1'h0;
	int   stuck = 0;

	// ----------------------------------------
	// Wired-AND lines with pull-ups
	// ----------------------------------------
	assign sclIn = ~(mScl | sclOe);
	assign sdaIn = ~(mSda | sdaOe);

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Release SCL and wait out a stretch of up to 2000 clocks
	task automatic rise();
		int n;
		n = 0;
		mScl <= 1'h0;
		@(posedge clk);
		while (sclIn !== 1'h1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 2000)
			stuck++;
		wt(3);
	endtask

	task automatic bitx(input logic b, output logic r);
		wt(2);
		mSda <= ~b;
		wt(2);
		rise();
		r = sdaIn;
		mScl <= 1'h1;
	endtask

	task automatic start();
		mSda <= 1'h1;
		wt(4);
		mScl <= 1'h1;
	endtask

	task automatic rstart();
		wt(2);
		mSda <= 1'h0;
		wt(2);
		rise();
		start();
	endtask

	task automatic stop();
		wt(2);
		mSda <= 1'h1;
		wt(2);
		rise();
		mSda <= 1'h0;
		wt(4);
	endtask

	// Byte MSB first, then the ninth clock
	task automatic xfer(input logic [7:0] d, input logic ao, output logic [7:0] r,
		output logic ack);
		for (int i = 7; i >= 0; i--)
			bitx(d[i], r[i]);
		bitx(ao, ack);
	endtask
endmodule

// file: bench/i2c_slave_receive_and_final_send_tb_top.sv
// Testbench for the two-wire slave core
`timescale 1ns/1ps
module i2c_slave_receive_and_final_send_tb_top;
	logic        ref_clk = 1'h0;
	logic        reset = 1'h1;
	logic [2:0]  avs_address = 3'h0;
	logic        avs_read = 1'h0;
	logic        avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        sclIn;
	logic        sdaIn;
	logic        sclOut;
	logic        sclOe;
	logic        sdaOut;
	logic        sdaOe;
	logic        wakeReq;
	logic        sleepActive = 1'h0;
	int          mismatches = 0;
	int          comparisons = 0;
	logic [7:0]  rnd = 8'h53;
	logic [6:0]  own;
	logic [7:0]  rd;
	logic [7:0]  d;
	logic        ack;

	always #10 ref_clk = ~ref_clk;

	isrfs_core u_dut (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sclIn(sclIn),
		.sdaIn(sdaIn), .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.sleepActive(sleepActive), .wakeReq(wakeReq));
	isrfs_master_model u_mst (.clk(ref_clk), .sclOe(sclOe), .sdaOe(sdaOe), .sclIn(sclIn),
		.sdaIn(sdaIn));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	function automatic logic [7:0] sla(input logic [6:0] a, input logic rw);
		return {a, rw};
	endfunction

	task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic av(input logic w, input logic [2:0] a, input logic [7:0] wd,
		output logic [7:0] r);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= {24'h000000, wd};
		avs_write <= w;
		avs_read <= ~w;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'h0 && n < 50);
		r = avs_readdata[7:0];
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		@(posedge ref_clk);
		if (n >= 50) begin
			mismatches++;
			stop_test();
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] wd);
		logic [7:0] r;
		av(1'h1, a, wd, r);
	endtask

	task automatic wctl(input logic [7:0] wd);
		wr(isrfs_pkg::OFF_CTRL, wd);
	endtask

	task automatic rdst(input logic [7:0] exp);
		logic [7:0] r;
		av(1'h0, isrfs_pkg::OFF_STATUS, 8'h00, r);
		chk("status", r & 8'hF8, exp);
	endtask

	task automatic waitIrq();
		logic [7:0] r;
		int n;
		n = 0;
		r = 8'h00;
		while (r[isrfs_pkg::B_IRQ] !== 1'h1 && n < 400) begin
			av(1'h0, isrfs_pkg::OFF_CTRL, 8'h00, r);
			n++;
		end
		if (n >= 400) begin
			mismatches++;
			stop_test();
		end
	endtask

	// Addressing, optionally after a repeated START
	task automatic addr(input logic rs, input logic rw, input logic [7:0] ea);
		if (rs)
			u_mst.rstart();
		else
			u_mst.start();
		u_mst.xfer(sla(own, rw), 1'h1, rd, ack);
		chk("addr ack", 8'(ack), ea);
	endtask

	task automatic txByte(input logic [7:0] c, input logic ma);
		rnd = lfsr(rnd);
		d = rnd;
		wr(isrfs_pkg::OFF_DATA, d);
		wctl(c);
		u_mst.xfer(8'hFF, ma, rd, ack);
		chk("tx byte", rd, d);
		waitIrq();
	endtask

	task automatic doReset();
		reset <= 1'h1;
		repeat (8) @(posedge ref_clk);
		reset <= 1'h0;
		@(posedge ref_clk);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		doReset();
		av(1'h0, isrfs_pkg::OFF_CTRL, 8'h00, rd);
		chk("ctrl reset", rd, 8'h00);
		av(1'h0, isrfs_pkg::OFF_OWNADDR, 8'h00, rd);
		chk("own reset", rd, isrfs_pkg::RST_OWNADDR);
		av(1'h0, isrfs_pkg::OFF_DATA, 8'h00, rd);
		chk("data reset", rd, isrfs_pkg::RST_DATA);
		wr(isrfs_pkg::OFF_STATUS, 8'h00);
		rdst(isrfs_pkg::C_NONE);
		wr(3'h5, 8'hFF);
		av(1'h0, 3'h5, 8'h00, rd);
		chk("unmapped", rd, 8'h00);
		rnd = lfsr(rnd);
		own = rnd[6:0] | 7'h01;
		wr(isrfs_pkg::OFF_OWNADDR, {own, 1'h1});
		wctl(8'h44);
		addr(1'h0, 1'h0, 8'h00);
		waitIrq();
		rdst(isrfs_pkg::C_SR_ADDR);
		chk("stretch", 8'(sclOe), 8'h01);
		for (int i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			d = rnd;
			wctl(i == 2 ? 8'h84 : 8'hC4);
			u_mst.xfer(d, 1'h1, rd, ack);
			chk("data ack", 8'(ack), i == 2 ? 8'h01 : 8'h00);
			waitIrq();
			rdst(i == 2 ? isrfs_pkg::C_SR_NACK : isrfs_pkg::C_SR_ACK);
			av(1'h0, isrfs_pkg::OFF_DATA, 8'h00, rd);
			chk("data", rd, d);
		end
		wctl(8'hC4);
		u_mst.stop();
		wctl(8'h04);
		addr(1'h0, 1'h0, 8'h01);
		u_mst.stop();
		wctl(8'h44);
		u_mst.start();
		u_mst.xfer(8'h00, 1'h1, rd, ack);
		chk("gc ack", 8'(ack), 8'h00);
		waitIrq();
		rdst(isrfs_pkg::C_SR_GCA);
		wctl(8'hC4);
		u_mst.stop();
		wr(isrfs_pkg::OFF_OWNADDR, {own, 1'h0});
		u_mst.start();
		u_mst.xfer(8'h00, 1'h1, rd, ack);
		chk("gc off", 8'(ack), 8'h01);
		u_mst.stop();
		// Send side: final byte acked, then queued START
		addr(1'h0, 1'h1, 8'h00);
		waitIrq();
		rdst(isrfs_pkg::C_ST_ADDR);
		txByte(8'hC4, 1'h0);
		rdst(isrfs_pkg::C_ST_ACK);
		txByte(8'h84, 1'h0);
		rdst(isrfs_pkg::C_ST_LAST);
		wctl(8'hA4);
		u_mst.stop();
		waitIrq();
		rdst(isrfs_pkg::C_START);
		chk("own start", {6'h00, sclOe, sdaOe}, 8'h03);
		wctl(8'h84);
		av(1'h0, isrfs_pkg::OFF_CTRL, 8'h00, rd);
		chk("released", {6'h00, sclOe, sdaOe}, 8'h00);
		addr(1'h0, 1'h0, 8'h01);
		u_mst.stop();
		wctl(8'h44);
		addr(1'h0, 1'h1, 8'h00);
		waitIrq();
		txByte(8'hC4, 1'h1);
		rdst(isrfs_pkg::C_ST_NACK);
		wctl(8'hC4);
		u_mst.stop();
		// Addressed again while own START is queued
		addr(1'h0, 1'h1, 8'h00);
		waitIrq();
		txByte(8'h84, 1'h0);
		rdst(isrfs_pkg::C_ST_LAST);
		wctl(8'hE4);
		addr(1'h1, 1'h0, 8'h00);
		waitIrq();
		rdst(isrfs_pkg::C_SR_ARB);
		// Release the stretch so the master can finish with a STOP
		wctl(8'hC4);
		u_mst.stop();
		doReset();
		// Address match while asleep
		wr(isrfs_pkg::OFF_OWNADDR, {own, 1'h1});
		wctl(8'h44);
		sleepActive <= 1'h1;
		addr(1'h0, 1'h0, 8'h00);
		waitIrq();
		chk("wake", {6'h00, wakeReq, sclOe}, 8'h03);
		sleepActive <= 1'h0;
		rdst(isrfs_pkg::C_SR_ADDR);
		wctl(8'hC4);
		av(1'h0, isrfs_pkg::OFF_CTRL, 8'h00, rd);
		chk("woken", {6'h00, wakeReq, sclOe}, 8'h00);
		u_mst.stop();
		chk("pin out", {6'h00, sclOut, sdaOut}, 8'h00);
		chk("stuck", 8'(u_mst.stuck), 8'h00);
		stop_test();
	end

	initial begin
		repeat (90000) @(posedge ref_clk);
		mismatches++;
		stop_test();
	end
endmodule
